// File: hdl/tcd_pkg.sv
// package: constants for the terminal command decoder
package tcd_pkg;
  // timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int FILT_TICK_NS    = 1_000_000;   // filter counts in 1 ms steps
  localparam int FILT_TICK_CYC   = FILT_TICK_NS / 10;
  localparam int FILT_MAX_MS     = 1000;        // 1.000 s
  localparam int FILT_DEF_MS     = 10;          // 0.010 s
  localparam int RATE_TICK_CYC   = CLK_HZ / 1000; // rate applied every 1 ms
  localparam int RATE_DEF        = 1000;        // 1.00 Hz/s in 0.001 units
  localparam int FRAC_DIV        = 1000;        // ms ticks per second
  // control-scheme codes
  localparam logic [1:0] MODE_2W1 = 2'h0;
  localparam logic [1:0] MODE_2W2 = 2'h1;
  localparam logic [1:0] MODE_3W1 = 2'h2;
  localparam logic [1:0] MODE_3W2 = 2'h3;
  // frequency routing of the selected preset
  localparam logic [1:0] DEST_SPEED = 2'h0;
  localparam logic [1:0] DEST_PID   = 2'h1;
  localparam logic [1:0] DEST_VF    = 2'h2;
  // terminal bit positions after filtering
  localparam int T_PS0 = 0;
  localparam int T_PS3 = 3;
  localparam int T_RS0 = 4;
  localparam int T_RS1 = 5;
  localparam int T_FWD = 6;
  localparam int T_REV = 7;
  localparam int T_EN  = 8;
  localparam int T_UP  = 9;
  localparam int T_DN  = 10;
  localparam int N_TERM = 11;
  // preset full scale is 100.0 % in 0.1 % units
  localparam int PCT_FULL = 1000;
endpackage

// File: hdl/tcd_terminal_command_decoder.sv
// module: terminal filter, preset/ramp select, run scheme and up/down ramp
`timescale 1ns/1ps
module tcd_terminal_command_decoder #(
  parameter int PW = 16,          // preset percent width
  parameter int FW = 24           // frequency width, 0.001 or 0.01 Hz units
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic [3:0]          presetSel,
  input  wire logic [1:0]          rampSel,
  input  wire logic                forwardRun,
  input  wire logic                reverseOrDirectionTerminal,
  input  wire logic                runEnableTerminal,
  input  wire logic                upTerminal,
  input  wire logic                downTerminal,
  input  wire logic [10:0]         filterMs,
  input  wire logic [1:0]          schemeMode,
  input  wire logic [1:0]          presetDest,
  input  wire logic                oneDecimal,
  input  wire logic [15:0]         upDownRate,
  input  wire logic [FW-1:0]       maxFreq,
  input  wire logic [16*PW-1:0]    presetTable,
  output logic [3:0]               presetIdx,
  output logic [FW-1:0]            presetFreq,
  output logic [PW-1:0]            pidRef,
  output logic [PW-1:0]            vfVoltRef,
  output logic [1:0]               rampPair,
  output logic                     runCmd,
  output logic                     dirReverse,
  output logic [FW-1:0]            setFreq
);
  localparam int NT = tcd_pkg::N_TERM;
  localparam int FCW = $clog2(tcd_pkg::FILT_MAX_MS + 1);
  localparam int MCW = $clog2(tcd_pkg::FILT_TICK_CYC);

  // elaboration checks: the percent field must hold full scale (1000)
  // and the frequency must hold the largest slew step with headroom
  initial begin
    if (PW < 11) begin
      $error("tcd: preset width below 11 bits");
    end
    if (FW < 17) begin
      $error("tcd: frequency width below 17 bits");
    end
  end

  // ==========================================================
  // input synchronisers
  // terminals are wired to switches and relays, so every one of them is
  // asynchronous; only sync_reg is read downstream
  logic [NT-1:0] rawIn;
  logic [NT-1:0] meta_reg;
  logic [NT-1:0] sync_reg;
  assign rawIn = {downTerminal, upTerminal, runEnableTerminal,
                  reverseOrDirectionTerminal, forwardRun, rampSel, presetSel};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= rawIn;
      sync_reg <= meta_reg;
    end
  end

  // ==========================================================
  // millisecond tick shared by filter and ramp
  // one free-running divider for both users: a filter time of F ms thus
  // accepts a level after F-1 to F ms, depending on the tick phase
  logic [MCW-1:0] msCnt_reg;
  logic [MCW-1:0] msCnt_next;
  logic           msTick;
  always_comb begin
    msTick = (msCnt_reg == MCW'(tcd_pkg::FILT_TICK_CYC - 1));
    msCnt_next = msTick ? '0 : msCnt_reg + 1'b1;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) msCnt_reg <= '0;
    else msCnt_reg <= msCnt_next;
  end

  // ==========================================================
  // filters: a level counts ms while it differs from the accepted one
  logic [10:0]   filtLim;
  logic [NT-1:0] filt_reg;
  logic [NT-1:0] filt_next;
  logic [FCW-1:0] fCnt_reg [NT];
  logic [FCW-1:0] fCnt_next [NT];
  assign filtLim = (filterMs > 11'(tcd_pkg::FILT_MAX_MS)) ?
                   11'(tcd_pkg::FILT_MAX_MS) : filterMs;

  generate
    for (genvar i = 0; i < NT; i++) begin : g_filt
      always_comb begin
        fCnt_next[i] = fCnt_reg[i];
        filt_next[i] = filt_reg[i];
        if (sync_reg[i] == filt_reg[i]) begin
          fCnt_next[i] = '0;
        end else if (FCW'(filtLim) == '0 ||
                     (msTick && fCnt_reg[i] + 1'b1 >= FCW'(filtLim))) begin
          filt_next[i] = sync_reg[i];
          fCnt_next[i] = '0;
        end else if (msTick) begin
          fCnt_next[i] = fCnt_reg[i] + 1'b1;
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          fCnt_reg[i] <= '0;
          filt_reg[i] <= 1'b0;
        end else begin
          fCnt_reg[i] <= fCnt_next[i];
          filt_reg[i] <= filt_next[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // preset and ramp selection
  // the scaled frequency is only driven when presets feed the speed
  // reference; the other two routes carry the raw percent, so that the
  // regulator or the V/f stage applies its own full scale
  logic [3:0]       idx;
  logic [PW-1:0]    pct;
  logic [FW+PW-1:0] prod;
  logic [FW-1:0]    pFreq_next;
  logic [PW-1:0]    pid_next;
  logic [PW-1:0]    vf_next;
  logic [1:0]       ramp_next;
  always_comb begin
    idx = filt_reg[tcd_pkg::T_PS3:tcd_pkg::T_PS0];
    pct = presetTable[idx*PW +: PW];
    // full-width product so no preset loses bits before the divide
    prod = (FW+PW)'(maxFreq) * (FW+PW)'(pct);
    pFreq_next = '0;
    pid_next = '0;
    vf_next = '0;
    ramp_next = filt_reg[tcd_pkg::T_RS1:tcd_pkg::T_RS0];
    if (presetDest == tcd_pkg::DEST_SPEED) begin
      pFreq_next = FW'(prod / (FW+PW)'(tcd_pkg::PCT_FULL));
    end
    if (presetDest == tcd_pkg::DEST_PID) begin
      pid_next = pct;
    end
    if (presetDest == tcd_pkg::DEST_VF) begin
      vf_next = pct;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      presetIdx  <= '0;
      presetFreq <= '0;
      pidRef     <= '0;
      vfVoltRef  <= '0;
      rampPair   <= '0;
    end else begin
      presetIdx  <= idx;
      presetFreq <= pFreq_next;
      pidRef     <= pid_next;
      vfVoltRef  <= vf_next;
      rampPair   <= ramp_next;
    end
  end

  // ==========================================================
  // run scheme decoding
  logic fwdL, revL, enL;
  logic fwdPrev_reg, revPrev_reg;
  logic run_next, dir_next;
  logic fwdRise, revRise;
  always_comb begin
    fwdL = filt_reg[tcd_pkg::T_FWD];
    revL = filt_reg[tcd_pkg::T_REV];
    enL = filt_reg[tcd_pkg::T_EN];
    fwdRise = fwdL && !fwdPrev_reg;
    revRise = revL && !revPrev_reg;
    run_next = runCmd;
    dir_next = dirReverse;
    unique case (schemeMode)
      tcd_pkg::MODE_2W1: begin
        run_next = fwdL ^ revL;
        // direction is kept while stopped, so a restart shows no glitch
        if (fwdL ^ revL) begin
          dir_next = revL;
        end
      end
      tcd_pkg::MODE_2W2: begin
        run_next = fwdL;
        dir_next = revL;
      end
      tcd_pkg::MODE_3W1: begin
        if (!enL) begin
          run_next = 1'b0;
        end else if (fwdRise) begin
          run_next = 1'b1;
          dir_next = 1'b0;
        end else if (revRise) begin
          run_next = 1'b1;
          dir_next = 1'b1;
        end
      end
      tcd_pkg::MODE_3W2: begin
        if (!enL) begin
          run_next = 1'b0;
        end else if (fwdRise) begin
          run_next = 1'b1;
        end
        dir_next = revL;
      end
    endcase
  end
  // edge memories follow the filtered level in every scheme, so entering
  // a three-wire scheme with a terminal already closed is not an edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      runCmd      <= 1'b0;
      dirReverse  <= 1'b0;
      fwdPrev_reg <= 1'b0;
      revPrev_reg <= 1'b0;
    end else begin
      runCmd      <= run_next;
      dirReverse  <= dir_next;
      fwdPrev_reg <= fwdL;
      revPrev_reg <= revL;
    end
  end

  // ==========================================================
  // up/down slew: rate in 0.001 (or 0.01) Hz/s units, same as setFreq
  // units, so each ms adds rate/1000 with the remainder carried
  // the remainder register makes slow rates exact over a second instead
  // of rounding every millisecond step down to zero
  logic [9:0]    frac_reg;
  logic [9:0]    frac_next;
  logic [FW-1:0] sf_next;
  logic [16:0]   acc;
  logic [FW-1:0] step;
  logic          upL;
  logic          dnL;
  always_comb begin
    upL = filt_reg[tcd_pkg::T_UP];
    dnL = filt_reg[tcd_pkg::T_DN];
    // decimal setting only rescales units, the raw count stays the same
    acc = 17'(frac_reg) + 17'(upDownRate);
    step = FW'(acc / 17'(tcd_pkg::FRAC_DIV));
    frac_next = frac_reg;
    sf_next = setFreq;
    // both terminals active cancel out, as do both idle
    if (msTick && (upL ^ dnL)) begin
      frac_next = 10'(acc % 17'(tcd_pkg::FRAC_DIV));
      if (upL) begin
        if (maxFreq - setFreq < step) begin
          sf_next = maxFreq;
        end else begin
          sf_next = setFreq + step;
        end
      end else begin
        if (setFreq < step) begin
          sf_next = '0;
        end else begin
          sf_next = setFreq - step;
        end
      end
    end
    // a lowered maximum pulls the set frequency down at once
    if (sf_next > maxFreq) begin
      sf_next = maxFreq;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      setFreq  <= '0;
      frac_reg <= '0;
    end else begin
      setFreq  <= sf_next;
      frac_reg <= frac_next;
    end
  end
endmodule

// File: dv/tcd_switch_bank.sv
// switch bank model: terminal contacts that chatter on every change
`timescale 1ns/1ps
module tcd_switch_bank #(
  parameter int BOUNCE = 3
) (
  input  wire logic        core_clk,
  input  wire logic [10:0] want,
  output logic      [10:0] pin
);
  logic [10:0] lastReg = 11'h000;
  logic [10:0] chgReg  = 11'h000;
  int          cntReg  = 0;
  // ======================================================
  // chatter: changed contacts flip back and forth a few cycles
  always_ff @(posedge core_clk) begin
    lastReg <= want;
    if (want != lastReg) begin
      chgReg <= want ^ lastReg;
      cntReg <= BOUNCE;
    end else if (cntReg > 0) begin
      cntReg <= cntReg - 1;
    end
  end
  assign pin = want ^ (cntReg[0] ? chgReg : 11'h000);
endmodule

// File: dv/tcd_checker.sv
// checker: selection and run-scheme relations at the decoder ports
`timescale 1ns/1ps
module tcd_checker (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [3:0]  presetSel,
  input wire logic [1:0]  rampSel,
  input wire logic        forwardRun,
  input wire logic        reverseOrDirectionTerminal,
  input wire logic        runEnableTerminal,
  input wire logic [10:0] filterMs,
  input wire logic [1:0]  schemeMode,
  input wire logic [3:0]  presetIdx,
  input wire logic [1:0]  rampPair,
  input wire logic        runCmd,
  input wire logic        dirReverse
);
  logic f, r, e, z;
  assign f = forwardRun;
  assign r = reverseOrDirectionTerminal;
  assign e = runEnableTerminal;
  // relations only hold with the filter bypassed (zero filter time)
  assign z = filterMs == 11'h000;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ======================================================
  // assertions
  property p_idx; ($stable(presetSel) && z)[*6] |-> presetIdx == presetSel;
  endproperty
  a_idx: assert property (p_idx) else $error("preset index wrong");
  property p_ramp; ($stable(rampSel) && z)[*6] |-> rampPair == rampSel;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp pair wrong");
  property p_tw1; (schemeMode == 2'h0 && $stable({f, r}) && z)[*6] |->
    runCmd == (f ^ r) && (!(f ^ r) || dirReverse == r); endproperty
  a_tw1: assert property (p_tw1) else $error("two-wire 1 wrong");
  property p_tw2; (schemeMode == 2'h1 && $stable({f, r}) && z)[*6] |->
    runCmd == f && (!f || dirReverse == r); endproperty
  a_tw2: assert property (p_tw2) else $error("two-wire 2 wrong");
  property p_stop; (schemeMode[1] && !e && z)[*6] |-> !runCmd; endproperty
  a_stop: assert property (p_stop) else $error("no stop on enable");
  property p_edge; (schemeMode == 2'h2 && e && !r && z)[*6] ##0 $rose(f)
    |-> ##[3:5] (runCmd && !dirReverse); endproperty
  a_edge: assert property (p_edge) else $error("no forward start");
  property p_lvl; (schemeMode == 2'h2 && f && z)[*6] ##0 ($rose(e) && !runCmd)
    |-> ##1 (!runCmd)[*8]; endproperty
  a_lvl: assert property (p_lvl) else $error("level started run");
  property p_dir2; (schemeMode == 2'h3 && $stable(r) && z)[*6] |->
    dirReverse == r; endproperty
  a_dir2: assert property (p_dir2) else $error("direction wrong");
  c_run3w1: cover property (schemeMode == 2'h2 && runCmd);
  c_run3w2: cover property (schemeMode == 2'h3 && runCmd && dirReverse);
  c_idx15: cover property (presetIdx == 4'hF);
endmodule
bind tcd_terminal_command_decoder tcd_checker chk_i (.*);

// File: dv/tb.sv
// testbench: table of terminal cases, then scheme, routing, filter, ramp
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [1:0] md;
    logic [8:0] w;
    logic       run;
    logic       dir;
  } tcd_row_t;
  logic         core_clk = 1'b0;
  logic         nrst = 1'b0;
  logic [10:0]  want = 11'h040;
  logic [10:0]  pin;
  logic [10:0]  filterMs = 11'h000;
  logic [1:0]   schemeMode = 2'h0;
  logic [1:0]   presetDest = 2'h0;
  logic [255:0] presetTable;
  logic [3:0]   presetIdx;
  logic [23:0]  presetFreq;
  logic [23:0]  setFreq;
  logic [15:0]  pidRef;
  logic [15:0]  vfVoltRef;
  logic [1:0]   rampPair;
  logic         runCmd;
  logic         dirReverse;
  int           err_total = 0;
  int           n_compared = 0;
  int           n;
  // bit 8 enable, 7 reverse, 6 forward, 5:4 ramp, 3:0 preset
  tcd_row_t rows [8] = '{'{2'h0, 9'h040, 1'b1, 1'b0},
    '{2'h0, 9'h091, 1'b1, 1'b1}, '{2'h0, 9'h0E2, 1'b0, 1'b1},
    '{2'h0, 9'h034, 1'b0, 1'b1}, '{2'h1, 9'h048, 1'b1, 1'b0},
    '{2'h1, 9'h0FF, 1'b1, 1'b1}, '{2'h3, 9'h085, 1'b0, 1'b1},
    '{2'h3, 9'h01A, 1'b0, 1'b0}};
  tcd_switch_bank sw (.core_clk(core_clk), .want(want), .pin(pin));
  tcd_terminal_command_decoder dut (.core_clk(core_clk), .nrst(nrst),
    .presetSel(pin[3:0]), .rampSel(pin[5:4]), .forwardRun(pin[6]),
    .reverseOrDirectionTerminal(pin[7]), .runEnableTerminal(pin[8]),
    .upTerminal(pin[9]), .downTerminal(pin[10]), .filterMs(filterMs),
    .schemeMode(schemeMode), .presetDest(presetDest), .oneDecimal(1'b0),
    .upDownRate(16'h0BB8), .maxFreq(24'h00C350), .presetTable(presetTable),
    .presetIdx(presetIdx), .presetFreq(presetFreq), .pidRef(pidRef),
    .vfVoltRef(vfVoltRef), .rampPair(rampPair), .runCmd(runCmd),
    .dirReverse(dirReverse), .setFreq(setFreq));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      err_total++;
    end
  endtask
  // settle time covers chatter plus sync, filter and output stages
  task automatic drv(input logic [1:0] m, input logic [10:0] w, input int c);
    @(posedge core_clk);
    schemeMode <= m;
    want <= w;
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #1_200_000;
    err_total++;
    end_of_test();
  end
  initial begin
    for (int k = 0; k < 16; k++) presetTable[k*16 +: 16] = 16'(60 * k + 100);
    repeat (16) @(posedge core_clk);
    #1 chk("rstRun", runCmd, 0);
    chk("rstFreq", setFreq, 0);
    @(posedge core_clk) nrst <= 1'b1;
    foreach (rows[i]) begin
      drv(rows[i].md, {2'b00, rows[i].w}, 12);
      chk("runCmd", runCmd, rows[i].run);
      chk("dirReverse", dirReverse, rows[i].dir);
      chk("presetIdx", presetIdx, rows[i].w[3:0]);
      chk("rampPair", rampPair, rows[i].w[5:4]);
      chk("presetFreq", presetFreq, 3000 * rows[i].w[3:0] + 5000);
    end
    drv(2'h2, 11'h100, 12); // operator closes enable first
    drv(2'h2, 11'h140, 12);
    chk("run3w1", runCmd, 1);
    drv(2'h2, 11'h100, 12);
    chk("pulse3w1", runCmd, 1);
    drv(2'h2, 11'h180, 12);
    chk("rev3w1", dirReverse, 1);
    drv(2'h2, 11'h000, 12); // operator stops by opening enable
    chk("stop3w1", runCmd, 0);
    drv(2'h2, 11'h040, 12);
    drv(2'h2, 11'h140, 12);
    chk("level3w1", runCmd, 0);
    drv(2'h3, 11'h180, 12);
    drv(2'h3, 11'h1C0, 12);
    chk("run3w2", {runCmd, dirReverse}, 3);
    drv(2'h3, 11'h140, 12);
    chk("dir3w2", {runCmd, dirReverse}, 2);
    drv(2'h3, 11'h040, 12);
    chk("stop3w2", runCmd, 0);
    for (int d = 1; d < 4; d++) begin
      @(posedge core_clk) presetDest <= d[1:0];
      drv(2'h0, 11'h00F, 12);
      chk("pidRef", pidRef, d == 1 ? 1000 : 0);
      chk("vfVoltRef", vfVoltRef, d == 2 ? 1000 : 0);
      chk("presetFreq", presetFreq, 0);
    end
    // a short blip must never reach the outputs
    @(posedge core_clk) filterMs <= 11'h002;
    drv(2'h0, 11'h000, 8);
    chk("blipIdx", presetIdx, 15);
    drv(2'h0, 11'h00F, 20);
    chk("filtIdx", presetIdx, 15);
    @(posedge core_clk) filterMs <= 11'h000;
    drv(2'h0, 11'h20F, 0);
    n = 0;
    while (n < 110000 && setFreq === 24'h000000) begin
      @(negedge core_clk);
      n++;
    end
    chk("setFreq", setFreq, 3);
    end_of_test();
  end
endmodule
